// [verilog/tdsm_map.vh]
/*
 Constants of the table-driven state machine: widths, table shape and
 the codes of the combined level and strength output value.
 Assumes it is included by its bare name into the design files.
*/
`ifndef TDSM_MAP_VH
`define TDSM_MAP_VH

// ----------------------------------------
// Vector widths and table shape
// ----------------------------------------
`define TDSM_IN_W        2
`define TDSM_OUT_W       2
`define TDSM_NSTATE      4
`define TDSM_STATE_W     2
`define TDSM_RESET_STATE 2'h0

// ----------------------------------------
// Output value code: {level[1:0], strength[1:0]}
// ----------------------------------------
`define TDSM_VAL_W       4
`define TDSM_LVL_LSB     2
`define TDSM_LVL_0       2'h0
`define TDSM_LVL_1       2'h1
`define TDSM_LVL_U       2'h2
`define TDSM_STR_S       2'h0
`define TDSM_STR_R       2'h1
`define TDSM_STR_Z       2'h2
`define TDSM_STR_U       2'h3

`endif

// [verilog/tdsm_outval.v]
/*
 Splits one combined output value into level, an unknown flag and a drive flag.
 Assumes the value code laid out in tdsm_map.vh.
*/
`timescale 1ns/1ps
`include "tdsm_map.vh"

module tdsm_outval (
   input  wire [`TDSM_VAL_W-1:0] i_val,    // Combined value
   output wire                   o_level,  // Logic level
   output wire                   o_unk,    // Level or strength undefined
   output wire                   o_drv_n   // Low while actively driven
);
   wire [1:0] lvl;
   wire [1:0] str;
   assign lvl = i_val[`TDSM_VAL_W-1:`TDSM_LVL_LSB];
   assign str = i_val[`TDSM_LVL_LSB-1:0];
   assign o_level = (lvl == `TDSM_LVL_1);
   assign o_unk   = (lvl == `TDSM_LVL_U) || (str == `TDSM_STR_U);
   assign o_drv_n = (str == `TDSM_STR_Z) || (str == `TDSM_STR_U);
endmodule

// [verilog/tdsm_top.v]
/*
 Table-driven state machine: a numbered present state, a per-state output
 value and a next-state table indexed by state and input combination.
 Assumes inputs synchronous to i_clk; outputs are consumed downstream.
*/
`timescale 1ns/1ps
`include "tdsm_map.vh"

// How it works
// - Outputs depend only on the present state, each state having one fixed value.
// - Each state lists a destination for every input combination and the matching one is taken.
// - States are numbered from zero and destinations name those numbers.
// - Each output bit carries a level of zero, one or unknown.
// - Each output bit also carries a strength of strong, resistive, high-z or undefined.
// - Reset and power-up put the machine in a configurable reset state, zero by default.
// - Input and output widths are fixed at build time and the table matches them.
module tdsm_top (
   input  wire                   i_clk,    // Clock, 125 MHz
   input  wire                   i_rst_n,  // Async reset, active low
   input  wire                   i_reset,  // Synchronous machine reset
   input  wire [`TDSM_IN_W-1:0]  i_in,     // Input vector
   output reg  [`TDSM_STATE_W-1:0] o_state, // Present state number
   output reg  [`TDSM_OUT_W-1:0] o_out,    // Output levels
   output reg  [`TDSM_OUT_W-1:0] o_unk,    // Output unknown flags
   output reg  [`TDSM_OUT_W-1:0] o_oe_n    // Output enables, low drives
);

   // ----------------------------------------
   // Transition and output tables
   // ----------------------------------------
   localparam NCOMB = 1 << `TDSM_IN_W;

   // Up/down counter example: input {reset, up}.
   function [`TDSM_STATE_W-1:0] next_of;
      input [`TDSM_STATE_W-1:0] st;
      input [`TDSM_IN_W-1:0]    in;
      begin
         if (in[1]) begin
            next_of = `TDSM_RESET_STATE;
         end else begin
            case (st)
               2'h0:    next_of = in[0] ? 2'h1 : 2'h3;
               2'h1:    next_of = in[0] ? 2'h2 : 2'h0;
               2'h2:    next_of = in[0] ? 2'h3 : 2'h1;
               2'h3:    next_of = in[0] ? 2'h0 : 2'h2;
               default: next_of = `TDSM_RESET_STATE;
            endcase
         end
      end
   endfunction

   // Per-state value of one output bit
   function [`TDSM_VAL_W-1:0] val_of;
      input [`TDSM_STATE_W-1:0] st;
      input integer             bitn;
      begin
         case (st)
            2'h0:    val_of = {`TDSM_LVL_0, `TDSM_STR_S};
            2'h1:    val_of = bitn == 0 ? {`TDSM_LVL_1, `TDSM_STR_S}
                                        : {`TDSM_LVL_0, `TDSM_STR_S};
            2'h2:    val_of = bitn == 0 ? {`TDSM_LVL_0, `TDSM_STR_S}
                                        : {`TDSM_LVL_1, `TDSM_STR_S};
            2'h3:    val_of = {`TDSM_LVL_1, `TDSM_STR_S};
            default: val_of = {`TDSM_LVL_U, `TDSM_STR_U};
         endcase
      end
   endfunction

   // ----------------------------------------
   // State register
   // ----------------------------------------
   reg  [`TDSM_STATE_W-1:0] state_q;
   reg  [`TDSM_STATE_W-1:0] state_d;
   wire [`TDSM_STATE_W-1:0] tbl [0:`TDSM_NSTATE*NCOMB-1];

   // Continuous assigns: a process that reads only constants may never wake
   genvar t;
   generate
      for (t = 0; t < `TDSM_NSTATE*NCOMB; t = t + 1) begin : g_tbl
         localparam integer ST = t / NCOMB;
         localparam integer CB = t % NCOMB;
         assign tbl[t] = next_of(ST[`TDSM_STATE_W-1:0], CB[`TDSM_IN_W-1:0]);
      end
   endgenerate

   always @* begin
      if (i_reset) begin
         state_d = `TDSM_RESET_STATE;
      end else begin
         state_d = tbl[{state_q, i_in}];
      end
   end

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         state_q <= `TDSM_RESET_STATE;
      end else begin
         state_q <= state_d;
      end
   end

   // ----------------------------------------
   // Output registers, decoded from next state
   // ----------------------------------------
   // Decoding the next state keeps outputs aligned with state_q, flop-driven.
   wire [`TDSM_OUT_W-1:0] lvl_d;
   wire [`TDSM_OUT_W-1:0] unk_d;
   wire [`TDSM_OUT_W-1:0] drv_n_d;

   genvar g;
   generate
      for (g = 0; g < `TDSM_OUT_W; g = g + 1) begin : g_out
         tdsm_outval u_val (
            .i_val   (val_of(state_d, g)),
            .o_level (lvl_d[g]),
            .o_unk   (unk_d[g]),
            .o_drv_n (drv_n_d[g])
         );
      end
   endgenerate

   always @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_state <= `TDSM_RESET_STATE;
         o_out   <= {`TDSM_OUT_W{1'b0}};
         o_unk   <= {`TDSM_OUT_W{1'b0}};
         o_oe_n  <= {`TDSM_OUT_W{1'b0}};
      end else begin
         o_state <= state_d;
         o_out   <= lvl_d;
         o_unk   <= unk_d;
         o_oe_n  <= drv_n_d;
      end
   end

endmodule

// [sim/tdsm_monitor.sv]
/* Port checker for tdsm_top. Assumes the fixed up/down table. */
`timescale 1ns/1ps
module tdsm_monitor (
   input wire       i_clk,   // Clock
   input wire       i_rst_n, // Async reset
   input wire       i_reset, // Sync reset
   input wire [1:0] i_in,    // Inputs
   input wire [1:0] o_state, // State
   input wire [1:0] o_out,   // Levels
   input wire [1:0] o_unk,   // Unknowns
   input wire [1:0] o_oe_n   // Enables
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   up_step_a: assert property (!i_reset && i_in == 2'h1 |=>
      o_state == $past(o_state) + 2'h1) else $error("no count up");
   down_step_a: assert property (!i_reset && i_in == 2'h0 |=>
      o_state == $past(o_state) - 2'h1) else $error("no count down");
   hold_clear_a: assert property (i_in[1] |=> !o_state) else $error("no clear");
   sync_reset_a: assert property (i_reset |=> !o_state) else $error("no reset");
   start_state_a: assert property ($rose(i_rst_n) |-> !o_state) else $error("bad start");
   out_map_a: assert property (o_out == o_state) else $error("bad output");
   unk_low_a: assert property (!o_unk) else $error("unknown set");
   drive_on_a: assert property (!o_oe_n) else $error("not driven");
   cover property (o_state == 2'h3 ##1 !o_state);
   cover property (!o_state ##1 o_state == 2'h3);
   cover property (i_reset && i_in == 2'h1);
endmodule
bind tdsm_top tdsm_monitor i_mon (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reset(i_reset),
   .i_in(i_in), .o_state(o_state), .o_out(o_out), .o_unk(o_unk), .o_oe_n(o_oe_n));

// [sim/tdsm_src.sv]
/* Surrounding logic driving the inputs. Caller times each change. */
`timescale 1ns/1ps
module tdsm_src (
   output logic       o_reset = 1'b0, // Sync reset
   output logic [1:0] o_in = 2'h0     // Input vector
);
   task apply(input logic r, input logic [1:0] v);
      {o_reset, o_in} = {r, v};
   endtask
endmodule

// [sim/tb.sv]
/* Bench for tdsm_top. Assumes tdsm_src and the bound monitor. */
`timescale 1ns/1ps
module tb;
   logic       i_clk = 1'b0, i_rst_n = 1'b0, rst;
   logic [1:0] in, st, ov, unk, oe_n;
   logic [1:0] exp = 2'h0;
   int         bad_count = 0, checks_done = 0;
   tdsm_src i_src (.o_reset(rst), .o_in(in));
   tdsm_top i_dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_reset(rst), .i_in(in), .o_state(st),
      .o_out(ov), .o_unk(unk), .o_oe_n(oe_n));
   initial forever #4 i_clk = ~i_clk;
   task check(input logic [3:0] seen, want);
      checks_done++;
      if (seen !== want) $display("wrong value at %0t: %h, expected %h", $time, seen, want);
      bad_count += (seen !== want);
   endtask
   task give_verdict;
      $display("checks %0d, errors %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task step(input logic r, input logic [1:0] v);
      i_src.apply(r, v);
      @(posedge i_clk) #1;
      exp = (r | v[1]) ? 2'h0 : (v[0] ? exp + 2'h1 : exp - 2'h1);
      check({st, ov}, {exp, exp});
      check({unk, oe_n}, 4'h0);
   endtask
   task t_clear;
      for (int k = 0; k < 6; k++) step(k == 5, k[0] && k < 5 ? 2'h2 + k[2:1] : 2'h1);
   endtask
   task t_up_down;
      for (int k = 0; k < 11; k++) step(1'b0, {1'b0, k < 5});
   endtask
   task t_async;
      i_rst_n = 1'b0;
      #2 check({st, ov}, 4'h0);
      @(posedge i_clk) #1 i_rst_n = 1'b1;
      exp = 2'h0;
      step(1'b0, 2'h1);
   endtask
   initial begin
      repeat (20) @(posedge i_clk);
      #1 i_rst_n = 1'b1;
      t_clear;
      t_up_down;
      t_async;
      give_verdict;
   end
   initial begin
      #20000 bad_count++;
      give_verdict;
   end
endmodule
